// ### src/btc_pkg.sv
package btc_pkg;

  // ----------------------------------------------------------------
  // Bus map (byte addresses on the AXI4-Lite port)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_MASK   = 8'h04;
  localparam logic [7:0]  OFS_ADDR   = 8'h08;
  localparam logic [7:0]  OFS_CSW    = 8'h0C;
  localparam logic [7:0]  OFS_STAT   = 8'h10;
  localparam logic [7:0]  OFS_RIDX   = 8'h14;
  localparam logic [7:0]  OFS_RDATA  = 8'h18;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CTRL_GO_BIT   = 0;
  localparam int          CTRL_MODE_LSB = 1;
  localparam int          CTRL_SEL_LSB  = 5;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_DONE_BIT = 1;
  localparam int          STAT_ILL_BIT  = 2;
  localparam int          STAT_WRD_LSB  = 3;
  localparam int          STAT_CYC_LSB  = 6;
  localparam int          CSW_C_BIT     = 0;
  localparam int          CSW_L_BIT     = 6;

  // ----------------------------------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CSW_RESET     = 16'h0000;
  localparam logic [15:0] MASK_RESET    = 16'h0000;
  localparam logic [23:0] ADDR_RESET    = 24'h000000;
  localparam logic [15:0] CSW_KEEP_MASK = 16'h7C00;
  localparam logic [4:0]  SEL_RETSTACK  = 5'h1F;
  localparam logic [4:0]  SEL_YPAIR     = 5'h1E;
  localparam logic [4:0]  SEL_CSW       = 5'h1D;

  typedef enum logic [3:0] {
    DST_WIDE, DST_NARROW, DST_RN, DST_RN_DISP, DST_SP_DISP,
    DST_ABS_SHORT, DST_PERIPH, DST_ABS16, DST_ABS24
  } dest_mode_e;

  // Cycle count of one operation for each destination form
  function automatic logic [2:0] op_cycles(input logic [3:0] m);
    case (m)
      DST_RN_DISP, DST_SP_DISP, DST_ABS16: op_cycles = 3'h3;
      DST_ABS24:                           op_cycles = 3'h4;
      default:                             op_cycles = 3'h2;
    endcase
  endfunction

  // Program words occupied for each destination form
  function automatic logic [2:0] op_words(input logic [3:0] m);
    case (m)
      DST_RN_DISP, DST_ABS16: op_words = 3'h3;
      DST_ABS24:              op_words = 3'h4;
      default:                op_words = 3'h2;
    endcase
  endfunction

endpackage

// ### src/bitfield_clear_path.sv
`timescale 1ns/10ps
module bitfield_clear_path
  import btc_pkg::*;
(
  input  wire logic [15:0] OPERAND,
  input  wire logic [15:0] MASK,
  output wire logic        ALL_SET,
  output wire logic [15:0] RESULT
);

  // An all-zero mask leaves every term true, so the test reads as set
  assign ALL_SET = &(OPERAND | ~MASK);
  assign RESULT  = OPERAND & ~MASK;

endmodule

// ### src/bitfield_test_clear_unit.sv
// What this block does
// - Carry set when every mask-selected operand bit is one, else cleared.
// - Mask-selected bits are cleared and the word written back to same place.
// - Mask is a 16-bit immediate; bits under zero mask bits stay unchanged.
// - Operation is read-modify-write: one destination read, then one write.
// - Status word destination: no carry test, but a zero mask sets carry; bits 14 to 10 kept, rest from result.
// - Other destinations: limiting flag set if limiting occurred on 36-bit move.
// - All-zero mask runs the form's full cycle count with no memory access and sets the carry flag.
// - Register destination takes 2 cycles and 2 program words.
// - Stack-relative short displacement takes 3 cycles and 2 words.
// - Wide register field refuses the return stack and Y pair encodings.
`timescale 1ns/10ps
module bitfield_test_clear_unit
  import btc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output wire logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output wire logic        S_AXI_WREADY,
  output wire logic [1:0]  S_AXI_BRESP,
  output wire logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output wire logic        S_AXI_ARREADY,
  output wire logic [31:0] S_AXI_RDATA,
  output wire logic [1:0]  S_AXI_RRESP,
  output wire logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        LIMIT_IN,
  output wire logic        MEM_RD,
  output wire logic        MEM_WR,
  output wire logic        MEM_PERIPH,
  output wire logic [23:0] MEM_ADDR,
  output wire logic [15:0] MEM_WDATA,
  input  wire logic [15:0] MEM_RDATA
);

  typedef enum logic {ST_IDLE, ST_RUN} state_e;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic        awv_q, wv_q, bvalid_q, rvalid_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [15:0] mask_q, csw_q, csw_d, operand_q, wdat_q;
  logic [23:0] addr_q;
  logic [4:0]  ridx_q, ridx_op_q;
  logic [15:0] regs_q [32];
  logic        done_q, ill_q, csw_dst_q, reg_dst_q, mem_dst_q, mask_nz_q, periph_q, wr_q;
  state_e      st_q;
  logic [2:0]  cnt_q, cyc_q, wrd_q;
  logic [3:0]  mode_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  wire        wr_fire  = awv_q && wv_q && !bvalid_q;
  wire        busy     = (st_q == ST_RUN);
  wire        hit_ctrl = (awaddr_q == OFS_CTRL);
  wire        hit_mask = (awaddr_q == OFS_MASK);
  wire        hit_addr = (awaddr_q == OFS_ADDR);
  wire        hit_csw  = (awaddr_q == OFS_CSW);
  wire        hit_ridx = (awaddr_q == OFS_RIDX);
  wire        hit_rdat = (awaddr_q == OFS_RDATA);
  wire        hit_stat = (awaddr_q == OFS_STAT);
  wire        wr_known = hit_ctrl | hit_mask | hit_addr | hit_csw | hit_ridx | hit_rdat
                         | hit_stat;
  wire [31:0] wmerged  = merge(32'h00000000, wdata_q, wstrb_q);
  wire [3:0]  req_mode = wdata_q[CTRL_MODE_LSB +: 4];
  wire [4:0]  req_sel  = wdata_q[CTRL_SEL_LSB +: 5];
  wire        go_req   = wr_fire && hit_ctrl && wstrb_q[0] && wdata_q[CTRL_GO_BIT] && !busy;
  wire        req_ill  = ((req_mode == DST_WIDE) &&
                          ((req_sel == SEL_RETSTACK) || (req_sel == SEL_YPAIR)))
                         || (req_mode > DST_ABS24);
  wire        start    = go_req && !req_ill;
  wire        req_csw  = (req_mode == DST_WIDE) && (req_sel == SEL_CSW);
  wire        req_reg  = (req_mode == DST_WIDE) || (req_mode == DST_NARROW);
  wire [4:0]  req_idx  = (req_mode == DST_NARROW) ? {3'h0, req_sel[1:0]} : req_sel;
  wire [15:0] req_opnd = req_csw ? csw_q : regs_q[req_idx];
  // Software writes to the status word and register file are dropped while busy
  wire        sw_csw   = wr_fire && hit_csw && !busy;
  wire        sw_rdat  = wr_fire && hit_rdat && !busy;

  assign S_AXI_AWREADY = !awv_q && !bvalid_q;
  assign S_AXI_WREADY  = !wv_q && !bvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      awv_q    <= 1'b0;
      awaddr_q <= 8'h00;
      wv_q     <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        awv_q    <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wv_q    <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        awv_q    <= 1'b0;
        wv_q     <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  wire [31:0] stat_word = {23'h000000, cyc_q, wrd_q, ill_q, done_q, busy};
  wire [31:0] rd_mux =
    (S_AXI_ARADDR == OFS_CTRL)  ? {22'h000000, ridx_op_q, mode_q, 1'b0} :
    (S_AXI_ARADDR == OFS_MASK)  ? {16'h0000, mask_q} :
    (S_AXI_ARADDR == OFS_ADDR)  ? {8'h00, addr_q} :
    (S_AXI_ARADDR == OFS_CSW)   ? {16'h0000, csw_q} :
    (S_AXI_ARADDR == OFS_STAT)  ? stat_word :
    (S_AXI_ARADDR == OFS_RIDX)  ? {27'h0000000, ridx_q} :
    (S_AXI_ARADDR == OFS_RDATA) ? {16'h0000, regs_q[ridx_q]} : 32'h00000000;
  wire        rd_known = (S_AXI_ARADDR <= OFS_RDATA) && (S_AXI_ARADDR[1:0] == 2'h0);

  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: read in cycle 0, result commits at cycle n-2, write in n-1
  // ----------------------------------------------------------------
  wire        commit     = busy && (cnt_q == cyc_q - 3'h2);
  wire        last       = busy && (cnt_q == cyc_q - 3'h1);
  wire        rd_cycle   = busy && (cnt_q == 3'h0) && mem_dst_q && mask_nz_q;
  wire [15:0] operand_cur = rd_cycle ? MEM_RDATA : operand_q;
  wire        all_set;
  wire [15:0] result;

  bitfield_clear_path u_path (
    .OPERAND (operand_cur),
    .MASK    (mask_q),
    .ALL_SET (all_set),
    .RESULT  (result)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q      <= ST_IDLE;
      cnt_q     <= 3'h0;
      cyc_q     <= 3'h0;
      wrd_q     <= 3'h0;
      mode_q    <= 4'h0;
      ridx_op_q <= 5'h00;
      csw_dst_q <= 1'b0;
      reg_dst_q <= 1'b0;
      mem_dst_q <= 1'b0;
      mask_nz_q <= 1'b0;
      periph_q  <= 1'b0;
      operand_q <= 16'h0000;
      done_q    <= 1'b0;
      ill_q     <= 1'b0;
    end else begin
      if (start) begin
        st_q      <= ST_RUN;
        cnt_q     <= 3'h0;
        cyc_q     <= op_cycles(req_mode);
        wrd_q     <= op_words(req_mode);
        mode_q    <= req_mode;
        ridx_op_q <= req_idx;
        csw_dst_q <= req_csw;
        reg_dst_q <= req_reg && !req_csw;
        mem_dst_q <= !req_reg;
        mask_nz_q <= (mask_q != 16'h0000);
        periph_q  <= (req_mode == DST_PERIPH);
        operand_q <= req_opnd;
        done_q    <= 1'b0;
        ill_q     <= 1'b0;
      end else if (go_req) begin
        ill_q <= 1'b1;
      end else if (last) begin
        st_q   <= ST_IDLE;
        done_q <= 1'b1;
      end else if (busy) begin
        cnt_q <= cnt_q + 3'h1;
      end
      if (rd_cycle) operand_q <= MEM_RDATA;
    end
  end

  // Memory write strobe and data come from flops, one cycle after commit
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_q   <= 1'b0;
      wdat_q <= 16'h0000;
    end else begin
      wr_q <= commit && mem_dst_q && mask_nz_q;
      if (commit) wdat_q <= result;
    end
  end

  assign MEM_RD     = rd_cycle;
  assign MEM_WR     = wr_q;
  assign MEM_WDATA  = wdat_q;
  assign MEM_ADDR   = addr_q;
  assign MEM_PERIPH = periph_q;

  // ----------------------------------------------------------------
  // Status word and software registers
  // ----------------------------------------------------------------
  always_comb begin
    csw_d = csw_q;
    if (sw_csw) begin
      csw_d = 16'(merge({16'h0000, csw_q}, wdata_q, wstrb_q));
    end else if (commit) begin
      if (csw_dst_q) begin
        // Caller keeps mask bits 14..10 clear; kept bits are never written anyway
        csw_d = (result & ~CSW_KEEP_MASK) | (csw_q & CSW_KEEP_MASK);
      end else begin
        csw_d[CSW_C_BIT] = all_set;
        csw_d[CSW_L_BIT] = csw_q[CSW_L_BIT] | LIMIT_IN;
      end
      if (!mask_nz_q) begin
        csw_d[CSW_C_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      csw_q  <= CSW_RESET;
      mask_q <= MASK_RESET;
      addr_q <= ADDR_RESET;
      ridx_q <= 5'h00;
    end else begin
      csw_q <= csw_d;
      if (wr_fire && hit_mask && !busy) begin
        mask_q <= 16'(merge({16'h0000, mask_q}, wmerged, wstrb_q));
      end
      if (wr_fire && hit_addr && !busy) begin
        addr_q <= 24'(merge({8'h00, addr_q}, wmerged, wstrb_q));
      end
      if (wr_fire && hit_ridx && wstrb_q[0]) begin
        ridx_q <= wdata_q[4:0];
      end
    end
  end

  generate
    for (genvar g = 0; g < 32; g++) begin : g_reg
      wire eng_wr = commit && reg_dst_q && (ridx_op_q == 5'(g));
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          regs_q[g] <= 16'h0000;
        end else if (eng_wr) begin
          regs_q[g] <= result;
        end else if (sw_rdat && (ridx_q == 5'(g))) begin
          regs_q[g] <= 16'(merge({16'h0000, regs_q[g]}, wdata_q, wstrb_q));
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  carry_test_a: assert property (@(posedge CLK) disable iff (!RST_N)
    commit && !csw_dst_q && !sw_csw |=> csw_q[CSW_C_BIT] == $past(all_set))
    else $error("carry does not follow mask test");
  clear_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
    MEM_WR |-> ((MEM_WDATA & mask_q) == 16'h0000))
    else $error("selected bits not cleared on write");
  untouched_a: assert property (@(posedge CLK) disable iff (!RST_N)
    MEM_WR |-> ((MEM_WDATA & ~mask_q) == (operand_q & ~mask_q)))
    else $error("unselected bits changed");
  rmw_order_a: assert property (@(posedge CLK) disable iff (!RST_N)
    MEM_RD |-> !MEM_WR ##1 !MEM_RD ##[0:2] MEM_WR)
    else $error("read not followed by a single write");
  csw_keep_a: assert property (@(posedge CLK) disable iff (!RST_N)
    commit && csw_dst_q |=> csw_q[14:10] == $past(csw_q[14:10]))
    else $error("status bits 14..10 changed");
  limit_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
    commit && !csw_dst_q && LIMIT_IN |=> csw_q[CSW_L_BIT])
    else $error("limiting flag not set");
  zero_mask_a: assert property (@(posedge CLK) disable iff (!RST_N)
    start && (mask_q == 16'h0000) |=> (!MEM_RD && !MEM_WR) [*2]
      ##[1:3] (!busy && csw_q[CSW_C_BIT]))
    else $error("zero mask did not idle and set carry");
  reg_timing_a: assert property (@(posedge CLK) disable iff (!RST_N)
    start && req_reg |=> busy [*2] ##1 !busy ##0 (wrd_q == 3'h2))
    else $error("register form not two cycles");
  sp_timing_a: assert property (@(posedge CLK) disable iff (!RST_N)
    start && (req_mode == DST_SP_DISP) |=> busy [*3] ##1 !busy ##0 (wrd_q == 3'h2))
    else $error("stack form not three cycles");
  illegal_sel_a: assert property (@(posedge CLK) disable iff (!RST_N)
    go_req && (req_mode == DST_WIDE) && (req_sel == SEL_YPAIR) |=> !busy && ill_q)
    else $error("refused register accepted");
  abs24_timing_a: assert property (@(posedge CLK) disable iff (!RST_N)
    start && (req_mode == DST_ABS24) |=> busy [*4] ##1 !busy ##0 (wrd_q == 3'h4))
    else $error("long absolute form not four cycles");

endmodule

// ### test/data_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Data memory with a same-cycle read path
// ----------------------------------------------------------------
module data_mem_model (
  input  wire logic        CLK,
  input  wire logic        MEM_RD,
  input  wire logic        MEM_WR,
  input  wire logic [23:0] MEM_ADDR,
  input  wire logic [15:0] MEM_WDATA,
  output logic      [15:0] MEM_RDATA
);
  logic [15:0] mem [256];
  logic [15:0] junk_q = 16'hA5C3;

  // Outside a read the bus rolls a pattern so stale data never passes for a read
  assign MEM_RDATA = MEM_RD ? mem[MEM_ADDR[7:0]] : junk_q;

  always @(posedge CLK) begin
    junk_q <= ~{junk_q[14:0], junk_q[15]};
    if (MEM_WR) begin
      mem[MEM_ADDR[7:0]] <= MEM_WDATA;
    end
  end
endmodule

// ### test/bitfield_test_clear_unit_tb.sv
`timescale 1ns/10ps
module bitfield_test_clear_unit_tb;
  import btc_pkg::*;
  localparam logic [2:0] NC [9] = '{3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h2, 3'h2, 3'h3, 3'h4};
  localparam logic [2:0] NW [9] = '{3'h2, 3'h2, 3'h2, 3'h3, 3'h2, 3'h2, 3'h2, 3'h3, 3'h4};
  localparam logic [7:0] OFSL [6] = '{OFS_CTRL, OFS_MASK, OFS_ADDR, OFS_CSW, OFS_STAT, OFS_RIDX};
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [7:0]  S_AXI_AWADDR = 8'h00;
  logic [7:0]  S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic        S_AXI_AWVALID = 1'b0;
  logic        S_AXI_WVALID = 1'b0;
  logic        S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0;
  logic        S_AXI_RREADY = 1'b0;
  logic        LIMIT_IN = 1'b0;
  wire logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  wire logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  wire logic [31:0] S_AXI_RDATA;
  wire logic        MEM_RD, MEM_WR, MEM_PERIPH;
  wire logic [23:0] MEM_ADDR;
  wire logic [15:0] MEM_WDATA, MEM_RDATA;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0, rd_at = 0, rd_cnt = 0, wr_cnt = 0;
  logic [65:0] exp_r [$];
  logic [1:0]  exp_b [$];
  logic [43:0] exp_m [$];
  logic [65:0] er;
  logic [43:0] em;

  always #4 CLK = ~CLK;

  bitfield_test_clear_unit i_bitfield_test_clear_unit (
    .CLK(CLK), .RST_N(RST_N),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .LIMIT_IN(LIMIT_IN),
    .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_PERIPH(MEM_PERIPH), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA)
  );

  data_mem_model i_data_mem_model (
    .CLK(CLK), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA)
  );

  // ----------------------------------------------------------------
  // Comparison, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Ready lines stay up once raised, so back-to-back calls never drive them twice in a step
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic ta, tw, tb;
    tb = 1'b0;
    exp_b.push_back(r);
    S_AXI_AWADDR <= ad;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (tb !== 1'b1) begin
      @(negedge CLK);
      ta = S_AXI_AWVALID & S_AXI_AWREADY;
      tw = S_AXI_WVALID & S_AXI_WREADY;
      tb = S_AXI_BVALID;
      @(posedge CLK);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] r = RESP_OKAY);
    logic ta, tr;
    tr = 1'b0;
    exp_r.push_back({r, m, e});
    S_AXI_ARADDR <= ad;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    while (tr !== 1'b1) begin
      @(negedge CLK);
      ta = S_AXI_ARVALID & S_AXI_ARREADY;
      tr = S_AXI_RVALID;
      @(posedge CLK);
      if (ta) S_AXI_ARVALID <= 1'b0;
    end
  endtask

  task automatic go(input logic [3:0] m, input logic [4:0] s, input logic poke);
    wr(OFS_CTRL, {22'h0, s, m, 1'b1});
    if (poke) wr(OFS_MASK, 32'hFFFF); // Lands while busy and must be lost
    repeat (6) @(posedge CLK);
  endtask

  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (S_AXI_BVALID && S_AXI_BREADY) check("bresp", 32'(S_AXI_BRESP), 32'(exp_b.pop_front()));
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      er = exp_r.pop_front();
      check("rdata", S_AXI_RDATA & er[63:32], er[31:0] & er[63:32]);
      check("rresp", 32'(S_AXI_RRESP), 32'(er[65:64]));
    end
    if (MEM_RD === 1'b1) begin
      rd_at <= cyc;
      rd_cnt <= rd_cnt + 1;
    end
    if (MEM_WR === 1'b1) begin
      em = exp_m.pop_front();
      wr_cnt <= wr_cnt + 1;
      check("mem wdata", 32'(MEM_WDATA), 32'(em[18:3]));
      check("mem addr", 32'(MEM_ADDR), 32'(em[42:19]));
      check("mem periph", 32'(MEM_PERIPH), 32'(em[43]));
      check("rmw spacing", cyc - rd_at, 32'(em[2:0]) - 1);
    end
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [23:0] a;
    logic [15:0] v, k, csw_e;
    logic        lim;
    void'($urandom(86234));
    csw_e = 16'h0000;
    a = 24'h0;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    foreach (OFSL[i]) rd(OFSL[i], 32'hFFFFFFFF, 32'h0);
    rd(8'h1C, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    wr(8'h1C, 32'h1, RESP_SLVERR);
    for (int m = 2; m <= 8; m++) begin
      a = 24'($urandom);
      v = 16'($urandom);
      k = 16'($urandom) | 16'h0001;
      lim = 1'($urandom);
      if (m % 2 == 1) v = v | k;
      i_data_mem_model.mem[a[7:0]] = v;
      LIMIT_IN <= lim;
      wr(OFS_MASK, {16'h0, k});
      wr(OFS_ADDR, {8'h0, a});
      exp_m.push_back({m == 6, a, v & ~k, NC[m]});
      go(4'(m), 5'h00, m == 8);
      csw_e[0] = (v & k) == k;
      csw_e[6] = csw_e[6] | lim;
      rd(OFS_CSW, 32'hFFFF, {16'h0, csw_e});
      rd(OFS_STAT, 32'h1FF, {23'h0, NC[m], NW[m], 3'b010});
      rd(OFS_MASK, 32'hFFFF, {16'h0, k});
    end
    check("mem reads", rd_cnt, 7);
    LIMIT_IN <= 1'b0;
    wr(OFS_MASK, 32'h0);
    go(4'h5, 5'h00, 1'b0);
    check("zero mask accesses", rd_cnt + wr_cnt, 14);
    csw_e[0] = 1'b1;
    rd(OFS_CSW, 32'hFFFF, {16'h0, csw_e});
    for (int j = 0; j < 2; j++) begin
      v = 16'($urandom);
      k = 16'($urandom) | 16'h8000;
      wr(OFS_RIDX, j ? 32'h2 : 32'h3);
      wr(OFS_RDATA, {16'h0, v});
      wr(OFS_MASK, {16'h0, k});
      go(4'(j), j ? 5'h06 : 5'h03, 1'b0);
      csw_e[0] = (v & k) == k;
      rd(OFS_RDATA, 32'hFFFF, {16'h0, v & ~k});
      rd(OFS_CSW, 32'hFFFF, {16'h0, csw_e});
      rd(OFS_STAT, 32'h1FF, 32'h92);
    end
    go(4'h0, SEL_RETSTACK, 1'b0);
    rd(OFS_STAT, 32'h5, 32'h4);
    go(4'h0, SEL_YPAIR, 1'b0);
    rd(OFS_STAT, 32'h5, 32'h4);
    LIMIT_IN <= 1'b1;
    wr(OFS_CSW, 32'hFC01);
    wr(OFS_MASK, 32'h0201);
    go(4'h0, SEL_CSW, 1'b0);
    rd(OFS_CSW, 32'hFFFF, 32'hFC00);
    go(4'hC, 5'h00, 1'b0);
    rd(OFS_STAT, 32'h5, 32'h4);
    S_AXI_WSTRB <= 4'h1;
    wr(OFS_ADDR, 32'h00ABCDEF);
    S_AXI_WSTRB <= 4'hF;
    rd(OFS_ADDR, 32'hFFFFFF, {8'h0, a[23:8], 8'hEF});
    tally_and_finish();
  end
endmodule
